// file: design/fsp_ctrl.sv
// Flash controller: sector guard register, page select, byte program, erase.
// Assumes the unlock sequence lives elsewhere and pulses unlock_req.
//
// Contract
// - Guarded sectors are never programmed or erased.
// - Reset clears every sector guard bit.
// - Guard and page select registers share one register location.
// - Writing 5EH to flash control selects the guard register.
// - Any other control write deselects it, restoring page select.
// - Selected guard register reads and writes at FF9H.
// - Guard writes can only set bits.
// - Set guard bits stay set until system reset.
// - Bytes program only on the active page while unlocked.
// - Erased bytes read FFH.
// - Programming only clears bits; erase alone sets them.
// - Debugger writes and program memory stores both program bytes.
// - Processor stalls while a byte programs; clock keeps running.
// - Page stays unlocked after a byte program completes.
// - Control writes other than erase codes relock the flash.
`timescale 1ns/1ps
`default_nettype none
module fsp_ctrl
  import fsp_pkg::*;
(
  input  wire logic              clk_sys,      // System clock, 10 MHz.
  input  wire logic              arst_n,       // Asynchronous reset, active low.
  input  wire fsp_reg_type       reg_bus,      // Register file access.
  output var  logic [7:0]        reg_rdata,    // Register read data.
  input  wire logic              unlock_req,   // Unlock sequence completed.
  input  wire logic              dbg_wr,       // Debugger memory write.
  input  wire fsp_prog_type      dbg_req,      // Debugger address and data.
  input  wire logic              cpu_store,    // Program memory store.
  input  wire fsp_prog_type      cpu_req,      // Store address and data.
  input  wire logic [FSP_AW-1:0] fetch_addr,   // Flash read address.
  output var  logic [FSP_DW-1:0] fetch_data,   // Flash read data.
  output var  logic              cpu_stall,    // Processor idles.
  output var  logic              unlocked,     // Flash is unlocked.
  output var  logic              prog_done     // Byte program finished.
);

  // Sector number of a flash address.
  function automatic logic [FSP_SECT_W-1:0] sector_of(input logic [FSP_AW-1:0] a);
    sector_of = a[FSP_SECT_LSB +: FSP_SECT_W];
  endfunction

  // True when the sector of an address is guarded.
  function automatic logic is_guarded(input logic [7:0] g, input logic [FSP_AW-1:0] a);
    is_guarded = g[sector_of(a)];
  endfunction

  logic          guard_sel;
  logic [7:0]    guard;
  logic [7:0]    page_sel;
  fsp_state_type state;
  fsp_prog_type  req;
  logic [7:0]    ptr;
  logic [7:0]    ptr_end;

  logic          next_guard_sel;
  logic [7:0]    next_guard;
  logic [7:0]    next_page_sel;
  logic          next_unlocked;
  logic [7:0]    next_reg_rdata;
  fsp_state_type next_state;
  fsp_prog_type  next_req;
  logic [7:0]    next_ptr;
  logic [7:0]    next_ptr_end;
  logic          next_stall;
  logic          next_done;

  logic              ctrl_wr;
  logic              shared_wr;
  logic              prog_valid;
  fsp_prog_type      prog_in;
  logic              mem_wr;
  logic [FSP_AW-1:0] mem_waddr;
  logic [FSP_DW-1:0] mem_wdata;
  logic [FSP_AW-1:0] mem_raddr;
  logic [FSP_DW-1:0] mem_rdata;

  assign ctrl_wr    = reg_bus.wr && (reg_bus.addr == FSP_ADDR_CTRL);
  assign shared_wr  = reg_bus.wr && (reg_bus.addr == FSP_ADDR_SHARED);
  // Debugger wins when both sources ask in one cycle; the processor is halted then anyway.
  assign prog_valid = dbg_wr || cpu_store;
  assign prog_in    = dbg_wr ? dbg_req : cpu_req;

  // Register file: selection, guard bits, page select and read data.
  always_comb begin
    next_guard_sel = guard_sel;
    next_guard     = guard;
    next_page_sel  = page_sel;
    next_unlocked  = unlocked;
    next_reg_rdata = FSP_ZERO_BYTE;
    if (ctrl_wr) begin
      next_guard_sel = (reg_bus.wdata == FSP_CODE_GUARD_SEL);
      if ((reg_bus.wdata != FSP_CODE_PAGE_ERASE) && (reg_bus.wdata != FSP_CODE_MASS_ERASE)) begin
        next_unlocked = 1'b0;
      end
    end else if (unlock_req) begin
      next_unlocked = 1'b1;
    end
    if (shared_wr) begin
      if (guard_sel) begin
        next_guard = guard | reg_bus.wdata;
      end else begin
        next_page_sel = reg_bus.wdata;
      end
    end
    if (reg_bus.rd) begin
      if (reg_bus.addr == FSP_ADDR_CTRL) begin
        next_reg_rdata = {6'h00, unlocked, guard_sel};
      end else if (reg_bus.addr == FSP_ADDR_SHARED) begin
        next_reg_rdata = guard_sel ? guard : page_sel;
      end
    end
  end

  // Guard bits only leave one through reset.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      guard_sel <= 1'b0;
      guard     <= FSP_GUARD_RST;
      page_sel  <= FSP_PAGE_RST;
      unlocked  <= 1'b0;
      reg_rdata <= FSP_ZERO_BYTE;
    end else begin
      guard_sel <= next_guard_sel;
      guard     <= next_guard;
      page_sel  <= next_page_sel;
      unlocked  <= next_unlocked;
      reg_rdata <= next_reg_rdata;
    end
  end

  // Program and erase sequencer; programming is read, merge, write.
  always_comb begin
    next_state   = state;
    next_req     = req;
    next_ptr     = ptr;
    next_ptr_end = ptr_end;
    next_done    = 1'b0;
    mem_wr       = 1'b0;
    mem_waddr    = ptr;
    mem_wdata    = FSP_ERASED;
    mem_raddr    = fetch_addr;
    unique case (state)
      FSP_IDLE: begin
        if (ctrl_wr && unlocked && (reg_bus.wdata == FSP_CODE_PAGE_ERASE)) begin
          if (!guard[page_sel[FSP_SECT_W-1:0]]) begin
            next_ptr     = {page_sel[FSP_SECT_W-1:0], FSP_PAGE_FIRST};
            next_ptr_end = {page_sel[FSP_SECT_W-1:0], FSP_PAGE_LAST};
            next_state   = FSP_ERASE;
          end
        end else if (ctrl_wr && unlocked && (reg_bus.wdata == FSP_CODE_MASS_ERASE)) begin
          // A mass erase would touch every sector, so any guard bit refuses it.
          if (guard == FSP_GUARD_RST) begin
            next_ptr     = FSP_ZERO_BYTE;
            next_ptr_end = FSP_PTR_LAST;
            next_state   = FSP_ERASE;
          end
        end else if (prog_valid && unlocked && !is_guarded(guard, prog_in.addr) &&
                     (sector_of(prog_in.addr) == page_sel[FSP_SECT_W-1:0])) begin
          next_req   = prog_in;
          next_state = FSP_READ;
        end
      end
      FSP_READ: begin
        mem_raddr  = req.addr;
        next_state = FSP_WRITE;
      end
      FSP_WRITE: begin
        mem_wr     = 1'b1;
        mem_waddr  = req.addr;
        mem_wdata  = mem_rdata & req.data;
        next_done  = 1'b1;
        next_state = FSP_IDLE;
      end
      FSP_ERASE: begin
        mem_wr    = 1'b1;
        mem_wdata = FSP_ERASED;
        next_ptr  = ptr + 8'h01;
        if (ptr == ptr_end) begin
          next_state = FSP_IDLE;
        end
      end
    endcase
    next_stall = (next_state != FSP_IDLE);
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state     <= FSP_IDLE;
      req       <= '0;
      ptr       <= FSP_ZERO_BYTE;
      ptr_end   <= FSP_ZERO_BYTE;
      cpu_stall <= 1'b0;
      prog_done <= 1'b0;
    end else begin
      state     <= next_state;
      req       <= next_req;
      ptr       <= next_ptr;
      ptr_end   <= next_ptr_end;
      cpu_stall <= next_stall;
      prog_done <= next_done;
    end
  end

  // The array read register feeds the fetch output directly.
  fsp_flash_mem u_mem (
    .clk_sys (clk_sys),
    .wr_en   (mem_wr),
    .wr_addr (mem_waddr),
    .wr_data (mem_wdata),
    .rd_addr (mem_raddr),
    .rd_data (mem_rdata)
  );
  assign fetch_data = mem_rdata;

  // Checks on guard behaviour, selection, and the program path.
  guard_no_clear_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (guard & ~$past(guard)) == (guard ^ $past(guard)))
    else $error("guard bit cleared without reset");
  guard_set_only_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    shared_wr && guard_sel |=> guard == ($past(guard) | $past(reg_bus.wdata)))
    else $error("guard write did not OR in data");
  select_on_code_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ctrl_wr && reg_bus.wdata == FSP_CODE_GUARD_SEL |=> guard_sel)
    else $error("guard register not selected");
  deselect_other_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ctrl_wr && reg_bus.wdata != FSP_CODE_GUARD_SEL |=> !guard_sel)
    else $error("guard register still selected");
  shared_page_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    shared_wr && !guard_sel |=> page_sel == $past(reg_bus.wdata) && guard == $past(guard))
    else $error("page select write misrouted");
  shared_read_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    reg_bus.rd && reg_bus.addr == FSP_ADDR_SHARED && guard_sel && !shared_wr |=> reg_rdata == guard)
    else $error("guard register not read at shared location");
  no_guarded_write_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    mem_wr |-> !guard[sector_of(mem_waddr)])
    else $error("guarded sector written");
  prog_merge_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    state == FSP_WRITE |-> mem_wdata == (mem_rdata & req.data))
    else $error("program set a bit");
  locked_idle_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    state == FSP_IDLE && !unlocked |=> state != FSP_READ)
    else $error("program started while locked");
  stall_prog_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    state == FSP_IDLE ##1 state == FSP_READ |-> cpu_stall ##1 cpu_stall ##1 !cpu_stall)
    else $error("stall window wrong");
  relock_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ctrl_wr && reg_bus.wdata != FSP_CODE_PAGE_ERASE && reg_bus.wdata != FSP_CODE_MASS_ERASE |=> !unlocked)
    else $error("flash not relocked");
  stay_unlocked_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    state == FSP_WRITE && unlocked && !ctrl_wr |=> unlocked)
    else $error("program changed lock state");

endmodule
`default_nettype wire

// file: design/fsp_pkg.sv
// Shared constants and types for the flash sector guard and byte programmer.
// Assumes an 8-bit register file bus and a small on-chip flash array.
package fsp_pkg;

  // Flash array geometry: eight sectors, one page per sector.
  localparam int unsigned FSP_AW        = 8;
  localparam int unsigned FSP_DW        = 8;
  localparam int unsigned FSP_SECT_W    = 3;
  localparam int unsigned FSP_SECT_LSB  = 5;
  localparam int unsigned FSP_DEPTH     = 256;

  // Register file locations.
  localparam logic [11:0] FSP_ADDR_CTRL   = 12'hFF8;
  localparam logic [11:0] FSP_ADDR_SHARED = 12'hFF9;

  // Control register codes; the two erase codes are arbitrary.
  localparam logic [7:0] FSP_CODE_GUARD_SEL  = 8'h5E;
  localparam logic [7:0] FSP_CODE_PAGE_ERASE = 8'hA5;
  localparam logic [7:0] FSP_CODE_MASS_ERASE = 8'hC3;

  // Reset and fill values.
  localparam logic [7:0] FSP_ERASED      = 8'hFF;
  localparam logic [7:0] FSP_GUARD_RST   = 8'h00;
  localparam logic [7:0] FSP_PAGE_RST    = 8'h00;
  localparam logic [7:0] FSP_ZERO_BYTE   = 8'h00;
  localparam logic [7:0] FSP_PTR_LAST    = 8'hFF;
  localparam logic [4:0] FSP_PAGE_LAST   = 5'h1F;
  localparam logic [4:0] FSP_PAGE_FIRST  = 5'h00;

  // One byte program request.
  typedef struct packed {
    logic [FSP_AW-1:0] addr;
    logic [FSP_DW-1:0] data;
  } fsp_prog_type;

  // One register file access.
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } fsp_reg_type;

  typedef enum logic [1:0] {
    FSP_IDLE,
    FSP_READ,
    FSP_WRITE,
    FSP_ERASE
  } fsp_state_type;

endpackage

// file: design/fsp_flash_mem.sv
// Flash cell array model: one write port, one read port with registered data.
// Assumes the controller merges program data itself; cells hold no reset.
`timescale 1ns/1ps
`default_nettype none
module fsp_flash_mem
  import fsp_pkg::*;
(
  input  wire logic              clk_sys,  // System clock.
  input  wire logic              wr_en,    // Write strobe.
  input  wire logic [FSP_AW-1:0] wr_addr,  // Write address.
  input  wire logic [FSP_DW-1:0] wr_data,  // Write data.
  input  wire logic [FSP_AW-1:0] rd_addr,  // Read address.
  output var  logic [FSP_DW-1:0] rd_data   // Registered read data.
);

  logic [FSP_DW-1:0] cells [FSP_DEPTH];

  // Cells are not reset, as real flash keeps its contents across reset.
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      cells[wr_addr] <= wr_data;
    end
    rd_data <= cells[rd_addr];
  end

endmodule
`default_nettype wire

// file: bench/fsp_ctrl_tb_top.sv
// Self-checking bench for the flash controller: guard register, page select, byte program and erase.
// Assumes fsp_pkg and fsp_ctrl are compiled first; inputs change on the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module fsp_ctrl_tb_top
  import fsp_pkg::*;
();
  typedef struct packed {
    logic        rd;
    logic [11:0] addr;
    logic [7:0]  data;
  } fsp_row_type;

  logic         clk_sys = 1'b0;
  logic         arst_n  = 1'b0;
  fsp_reg_type  reg_bus;
  logic [7:0]   reg_rdata;
  logic         unlock_req;
  logic         dbg_wr;
  logic         cpu_store;
  fsp_prog_type dbg_req;
  fsp_prog_type cpu_req;
  logic [7:0]   fetch_addr;
  logic [7:0]   fetch_data;
  logic         cpu_stall;
  logic         unlocked;
  logic         prog_done;
  int           n_fail    = 0;
  int           tests_run = 0;

  // Register script: writes, and reads beside the byte each read must return.
  fsp_row_type rows [18] = '{
    '{1'b0, 12'hFF8, 8'h00}, '{1'b0, 12'hFF8, 8'h5E}, '{1'b1, 12'hFF8, 8'h01},
    '{1'b1, 12'hFF9, 8'h00}, '{1'b0, 12'hFF9, 8'h01}, '{1'b1, 12'hFF9, 8'h01},
    '{1'b0, 12'hFF9, 8'h02}, '{1'b1, 12'hFF9, 8'h03}, '{1'b0, 12'hFF9, 8'h00},
    '{1'b1, 12'hFF9, 8'h03}, '{1'b0, 12'hFF8, 8'h00}, '{1'b1, 12'hFF8, 8'h00},
    '{1'b0, 12'hFF9, 8'h02}, '{1'b1, 12'hFF9, 8'h02}, '{1'b1, 12'hF00, 8'h00},
    '{1'b0, 12'hFF8, 8'h5E}, '{1'b1, 12'hFF9, 8'h03}, '{1'b0, 12'hFF8, 8'h00}};

  // Free-running 10 MHz system clock.
  always #50 clk_sys = ~clk_sys;

  fsp_ctrl i_fsp_ctrl (
    .clk_sys    (clk_sys),
    .arst_n     (arst_n),
    .reg_bus    (reg_bus),
    .reg_rdata  (reg_rdata),
    .unlock_req (unlock_req),
    .dbg_wr     (dbg_wr),
    .dbg_req    (dbg_req),
    .cpu_store  (cpu_store),
    .cpu_req    (cpu_req),
    .fetch_addr (fetch_addr),
    .fetch_data (fetch_data),
    .cpu_stall  (cpu_stall),
    .unlocked   (unlocked),
    .prog_done  (prog_done)
  );

  // Byte and bit comparisons; case inequality so an unknown never matches.
  task automatic chk8(input logic [7:0] exp, input logic [7:0] act);
    tests_run++;
    if (act !== exp) begin
      n_fail++;
      $display("Error at %0t: expected %h, got %h", $time, exp, act);
    end
  endtask

  // Cycle counts are two-state, so an unknown cannot slip through here.
  task automatic chk_n(input int exp, input int act);
    tests_run++;
    if (act != exp) begin
      n_fail++;
      $display("Error at %0t: expected %h, got %h", $time, exp, act);
    end
  endtask

  task automatic chk1(input logic exp, input logic act);
    tests_run++;
    if (act !== exp) begin
      n_fail++;
      $display("Error at %0t: expected %h, got %h", $time, exp, act);
    end
  endtask

  // The single place where the run ends.
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // One-cycle register strobes; read data is checked while it stands.
  task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_bus = '{1'b1, 1'b0, a, d};
    @(negedge clk_sys);
    reg_bus = '0;
  endtask

  task automatic reg_rd(input logic [11:0] a, input logic [7:0] exp);
    @(negedge clk_sys);
    reg_bus = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk_sys);
    reg_bus = '0;
    chk8(exp, reg_rdata);
  endtask

  task automatic fetch(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_sys);
    fetch_addr = a;
    @(negedge clk_sys);
    chk8(exp, fetch_data);
  endtask

  task automatic unlock;
    @(negedge clk_sys);
    unlock_req = 1'b1;
    @(negedge clk_sys);
    unlock_req = 1'b0;
    chk1(1'b1, unlocked);
  endtask

  // A taken program stalls two cycles, then pulses done; a dropped one shows nothing.
  task automatic prog(input logic cpu, input logic [7:0] a, input logic [7:0] d, input logic take);
    @(negedge clk_sys);
    if (cpu) begin
      cpu_store = 1'b1;
      cpu_req   = '{a, d};
    end else begin
      dbg_wr  = 1'b1;
      dbg_req = '{a, d};
    end
    @(negedge clk_sys);
    dbg_wr    = 1'b0;
    cpu_store = 1'b0;
    chk1(take, cpu_stall);
    @(negedge clk_sys);
    chk1(take, cpu_stall);
    @(negedge clk_sys);
    chk1(1'b0, cpu_stall);
    chk1(take, prog_done);
  endtask

  // Erase waits are bounded; a hang counts as a mismatch and ends the run.
  task automatic erase(input logic [7:0] code, input logic take);
    int i;
    int n_exp;
    n_exp = 0;
    if (take) begin
      n_exp = (code == FSP_CODE_MASS_ERASE) ? FSP_DEPTH : FSP_PAGE_LAST + 1;
    end
    reg_wr(FSP_ADDR_CTRL, code);
    chk1(take, cpu_stall);
    for (i = 0; i < 300 && cpu_stall; i++) @(negedge clk_sys);
    if (cpu_stall !== 1'b0) begin
      n_fail++;
      print_verdict();
    end
    chk_n(n_exp, i);
  endtask

  // Main sequence: register table first, then the awkward program and erase cases.
  initial begin
    reg_bus = '0; unlock_req = 1'b0; dbg_wr = 1'b0; cpu_store = 1'b0;
    dbg_req = '0; cpu_req = '0; fetch_addr = 8'h00;
    repeat (5) @(negedge clk_sys);
    arst_n = 1'b1;
    chk1(1'b0, unlocked);
    chk1(1'b0, cpu_stall);
    foreach (rows[k]) begin
      if (rows[k].rd) reg_rd(rows[k].addr, rows[k].data);
      else reg_wr(rows[k].addr, rows[k].data);
    end
    unlock();
    erase(FSP_CODE_PAGE_ERASE, 1'b1);
    chk1(1'b1, unlocked);
    fetch(8'h45, FSP_ERASED);
    prog(1'b0, 8'h45, 8'hF0, 1'b1);
    fetch(8'h45, 8'hF0);
    prog(1'b1, 8'h45, 8'h3C, 1'b1);
    fetch(8'h45, 8'h30);
    prog(1'b0, 8'h45, 8'hFF, 1'b1);
    fetch(8'h45, 8'h30);
    prog(1'b0, 8'h65, 8'h00, 1'b0);
    // Page 0 sits in a guarded sector, so every change to it must be dropped.
    reg_wr(FSP_ADDR_SHARED, 8'h00);
    prog(1'b0, 8'h05, 8'h00, 1'b0);
    erase(FSP_CODE_PAGE_ERASE, 1'b0);
    erase(FSP_CODE_MASS_ERASE, 1'b0);
    reg_wr(FSP_ADDR_SHARED, 8'h02);
    reg_wr(FSP_ADDR_CTRL, 8'h00);
    chk1(1'b0, unlocked);
    prog(1'b0, 8'h46, 8'h00, 1'b0);
    fetch(8'h46, FSP_ERASED);
    unlock();
    reg_wr(FSP_ADDR_CTRL, FSP_CODE_GUARD_SEL);
    chk1(1'b0, unlocked);
    reg_rd(FSP_ADDR_SHARED, 8'h03);
    // A reset in mid-run must discard the sticky guard bits.
    @(negedge clk_sys);
    arst_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    arst_n = 1'b1;
    reg_wr(FSP_ADDR_CTRL, FSP_CODE_GUARD_SEL);
    reg_rd(FSP_ADDR_SHARED, FSP_GUARD_RST);
    reg_rd(FSP_ADDR_CTRL, 8'h01);
    // With no guard bit left, a mass erase must run and return every byte to ones.
    unlock();
    erase(FSP_CODE_MASS_ERASE, 1'b1);
    fetch(8'h45, FSP_ERASED);
    fetch(8'h05, FSP_ERASED);
    print_verdict();
  end
endmodule
`default_nettype wire
